// >>> rtl/cfg_word_store.sv
// Small word memory with a registered bus read port and a registered scan read port
`timescale 1ns/100ps
`default_nettype none
module cfg_word_store #(
  parameter int W     = 16,
  parameter int DEPTH = 32,
  parameter int AW    = 5,
  parameter int BW    = 32
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_srst,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic          i_a_en,
  input  wire logic          i_a_use_mem,
  input  wire logic [AW-1:0] i_a_addr,
  input  wire logic [BW-1:0] i_a_alt,
  output logic      [BW-1:0] o_a_q,
  input  wire logic [AW-1:0] i_b_addr,
  output logic      [W-1:0]  o_b_q
);
  logic [W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW) || BW < W) begin
      $error("cfg_word_store: unsupported parameters");
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Bus read data, zero outside a read cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !i_a_en) begin
      o_a_q <= '0;
    end else if (i_a_use_mem) begin
      o_a_q <= BW'(mem[i_a_addr]);
    end else begin
      o_a_q <= i_a_alt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_b_q <= '0;
    end else begin
      o_b_q <= mem[i_b_addr];
    end
  end
endmodule
`default_nettype wire

// >>> rtl/serial_gpio_shift_chain.sv
// Serial expander controller driving an external shift register chain
//
// Overview of operation
// - Up to 128 bits handled, as 32 ports of up to four bits.
// - Bits shift out on the data pin; a load strobe follows each burst.
// - The data input is sampled every bit into readable captured registers.
// - Disabled ports are skipped and take no serial clock cycles.
// - Bits per enabled port are 1 to 4, the same for all ports.
// - Enables and width govern both directions; each bit outputs and captures.
// - A burst never exceeds 32 times 4 data clocks.
// - Repeated bursts are separated by a 1 ms stepped gap, or none.
// - The single-shot control launches one burst and clears itself after.
// - Auto-repeat keeps issuing bursts until software clears it.
// - Each output bit value comes from its port's per-bit source field.
// - The serial clock rate follows the clock divider field.
// - One load pulse per burst, shortest legal length, selectable polarity.
// - Inputs latched at one load arrive in the following burst.
// - Port order of output and input streams reverses independently.
// - Each output bit is static, blink or activity, with PWM and inversion.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "serial_gpio_shift_chain_defines.svh"
module serial_gpio_shift_chain #(
  parameter int GAP_STEP_CYCLES   = `SGC_GAP_STEP_US * `SGC_REF_CLK_KHZ / 1000,
  parameter int BLINK_HALF_CYCLES = `SGC_BLINK_HALF_US * `SGC_REF_CLK_KHZ / 1000
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_srst,
  input  wire logic [`SGC_ADDR_W-1:0] i_addr,
  input  wire logic [`SGC_DATA_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [`SGC_DATA_W-1:0] o_rdata,
  input  wire logic                   i_chain_data_in,
  input  wire logic [31:0]            i_port_activity,
  output logic                        o_chain_clock_out,
  output logic                        o_chain_data_out,
  output logic                        o_chain_load_strobe
);
  localparam int NP = `SGC_NUM_PORTS;
  localparam int LOAD_MIN = (`SGC_LOAD_MIN_NS + `SGC_REF_PERIOD_NS - 1) / `SGC_REF_PERIOD_NS;
  localparam int LOAD_CYC = (LOAD_MIN < 1) ? 1 : LOAD_MIN;

  initial begin
    if (GAP_STEP_CYCLES < 1 || BLINK_HALF_CYCLES < 1 || GAP_STEP_CYCLES > 65535 ||
        BLINK_HALF_CYCLES > 16777215) begin
      $error("serial_gpio_shift_chain: unsupported timing parameters");
    end
  end

  serial_gpio_pkg::shift_state_e    state_r;
  serial_gpio_pkg::general_config_s gen_r;
  serial_gpio_pkg::port_cfg_s       pcfg;
  logic [7:0]  clock_divider_sel_r;
  logic [31:0] port_enable_mask_r;
  logic [31:0] mask_lat_r;
  logic [7:0]  pwm_duty_r;
  logic [127:0] captured_inputs_r;
  logic [4:0]  out_port_r;
  logic [4:0]  in_port_r;
  logic [1:0]  bit_idx_r;
  logic [8:0]  phase_r;
  logic [15:0] step_cnt_r;
  logic [5:0]  gap_ms_r;
  logic [7:0]  burst_bits_r;
  logic [23:0] blink_cnt_r;
  logic        blink_r;
  logic [7:0]  pwm_cnt_r;
  logic        din_meta_r;
  logic        din_sync_r;
  logic [31:0] act_meta_r;
  logic [31:0] act_sync_r;
  logic [15:0] scan_q;
  logic [`SGC_DATA_W-1:0] alt_rdata;
  logic [8:0]  half_len;
  logic [5:0]  first_out;
  logic [5:0]  first_in;
  logic [5:0]  next_out;
  logic [5:0]  next_in;
  logic        wr_general;
  logic        phase_end;
  logic        port_done;
  logic        sample_now;
  logic        load_end;
  logic        gap_end;
  logic        start_burst;
  logic        bit_value;
  logic [6:0]  cap_idx;
  logic        load_pol_r;

  // Nearest enabled port at or beyond start in the chosen direction
  function automatic logic [5:0] find_port(input logic [31:0] m, input int start,
                                           input logic up);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (up && m[i] && i >= start) begin
        res = {1'b1, 5'(i)};
      end
    end
    for (int i = 0; i < 32; i++) begin
      if (!up && m[i] && i <= start) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  assign wr_general  = i_wr && (i_addr == `SGC_OFS_GENERAL);
  assign half_len    = {1'b0, clock_divider_sel_r} + 9'(`SGC_HALF_EXTRA);
  assign phase_end   = (phase_r == half_len - 9'h001);
  assign port_done   = (bit_idx_r == gen_r.bits_per_port);
  assign sample_now  = (state_r == serial_gpio_pkg::ST_LOW) && phase_end;
  assign load_end    = (state_r == serial_gpio_pkg::ST_LOAD) && (phase_r == 9'(LOAD_CYC - 1));
  assign gap_end     = (step_cnt_r == 16'(GAP_STEP_CYCLES - 1)) &&
                       (gap_ms_r == {1'b0, gen_r.gap_length});
  assign start_burst = (state_r == serial_gpio_pkg::ST_IDLE) &&
                       (gen_r.one_burst_go || gen_r.repeat_bursts);
  assign cap_idx     = {in_port_r, bit_idx_r};
  // Reverse order walks the same enabled set from the other end
  // independent order per direction
  assign first_out = find_port(port_enable_mask_r, gen_r.flip_out_order ? 31 : 0,
                               !gen_r.flip_out_order);
  assign first_in  = find_port(port_enable_mask_r, gen_r.flip_in_order ? 31 : 0,
                               !gen_r.flip_in_order);
  assign next_out  = find_port(mask_lat_r, gen_r.flip_out_order ? int'(out_port_r) - 1 :
                               int'(out_port_r) + 1, !gen_r.flip_out_order);
  assign next_in   = find_port(mask_lat_r, gen_r.flip_in_order ? int'(in_port_r) - 1 :
                               int'(in_port_r) + 1, !gen_r.flip_in_order);

  assign pcfg = serial_gpio_pkg::port_cfg_s'(scan_q);
  always_comb begin
    case (pcfg.src[bit_idx_r])
      serial_gpio_pkg::SRC_LOW:      bit_value = 1'b0;
      serial_gpio_pkg::SRC_HIGH:     bit_value = 1'b1;
      serial_gpio_pkg::SRC_BLINK:    bit_value = blink_r;
      serial_gpio_pkg::SRC_ACTIVITY: bit_value = blink_r && act_sync_r[out_port_r];
      default:                       bit_value = 1'b0;
    endcase
    bit_value = (bit_value && (!pcfg.pwm_en[bit_idx_r] || (pwm_cnt_r < pwm_duty_r))) ^
                pcfg.invert[bit_idx_r];
  end

  always_comb begin
    alt_rdata = '0;
    case (i_addr)
      `SGC_OFS_GENERAL: begin
        alt_rdata = {(state_r != serial_gpio_pkg::ST_IDLE), 18'h00000, gen_r};
      end
      `SGC_OFS_CLOCK:   alt_rdata = {24'h000000, clock_divider_sel_r};
      `SGC_OFS_ENABLE:  alt_rdata = port_enable_mask_r;
      `SGC_OFS_PWM:     alt_rdata = {24'h000000, pwm_duty_r};
      default: begin
        if (i_addr >= `SGC_OFS_CAPT0 && i_addr <= `SGC_OFS_CAPT3 && i_addr[1:0] == 2'h0) begin
          alt_rdata = captured_inputs_r[32 * int'(i_addr[3:2]) +: 32];
        end
      end
    endcase
  end

  cfg_word_store #(
    .W     (`SGC_PORT_CFG_W),
    .DEPTH (NP),
    .AW    (5),
    .BW    (`SGC_DATA_W)
  ) cfg_word_store_inst (
    .i_ref_clk   (i_ref_clk),
    .i_srst      (i_srst),
    .i_we        (i_wr && i_addr[`SGC_OFS_PORT_BIT]),
    .i_waddr     (i_addr[6:2]),
    .i_wdata     (i_wdata[`SGC_PORT_CFG_W-1:0]),
    .i_a_en      (i_rd),
    .i_a_use_mem (i_addr[`SGC_OFS_PORT_BIT]),
    .i_a_addr    (i_addr[6:2]),
    .i_a_alt     (alt_rdata),
    .o_a_q       (o_rdata),
    .i_b_addr    (out_port_r),
    .o_b_q       (scan_q)
  );

  // Software writes win over the hardware clear of the single-shot bit
  // single shot clears itself
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      gen_r <= serial_gpio_pkg::general_config_s'(`SGC_RST_GENERAL);
    end else if (wr_general) begin
      gen_r <= serial_gpio_pkg::general_config_s'(i_wdata[`SGC_GENERAL_W-1:0]);
    end else if (load_end) begin
      gen_r.one_burst_go <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      clock_divider_sel_r <= `SGC_RST_CLOCK;
      port_enable_mask_r  <= `SGC_RST_ENABLE;
      pwm_duty_r          <= `SGC_RST_PWM;
    end else if (i_wr) begin
      if (i_addr == `SGC_OFS_CLOCK) clock_divider_sel_r <= i_wdata[7:0];
      if (i_addr == `SGC_OFS_ENABLE) port_enable_mask_r <= i_wdata;
      if (i_addr == `SGC_OFS_PWM) pwm_duty_r <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      din_meta_r <= 1'b0;
      din_sync_r <= 1'b0;
      act_meta_r <= '0;
      act_sync_r <= '0;
    end else begin
      din_meta_r <= i_chain_data_in;
      din_sync_r <= din_meta_r;
      act_meta_r <= i_port_activity;
      act_sync_r <= act_meta_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
      pwm_cnt_r   <= '0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
      if (blink_cnt_r == 24'(BLINK_HALF_CYCLES - 1)) begin
        blink_cnt_r <= '0;
        blink_r     <= !blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 24'h000001;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_r    <= serial_gpio_pkg::ST_IDLE;
      mask_lat_r <= '0;
      out_port_r <= '0;
      in_port_r  <= '0;
      bit_idx_r  <= '0;
      phase_r    <= '0;
      step_cnt_r <= '0;
      gap_ms_r   <= '0;
    end else begin
      case (state_r)
        serial_gpio_pkg::ST_IDLE: begin
          phase_r <= '0;
          if (start_burst) begin
            mask_lat_r <= port_enable_mask_r;
            out_port_r <= first_out[4:0];
            in_port_r  <= first_in[4:0];
            bit_idx_r  <= '0;
            state_r    <= first_out[5] ? serial_gpio_pkg::ST_FETCH : serial_gpio_pkg::ST_LOAD;
          end
        end
        serial_gpio_pkg::ST_FETCH: begin
          state_r <= serial_gpio_pkg::ST_LOW;
        end
        serial_gpio_pkg::ST_LOW: begin
          phase_r <= phase_end ? 9'h000 : phase_r + 9'h001;
          if (phase_end) state_r <= serial_gpio_pkg::ST_HIGH;
        end
        serial_gpio_pkg::ST_HIGH: begin
          phase_r <= phase_end ? 9'h000 : phase_r + 9'h001;
          if (phase_end && !port_done) begin
            bit_idx_r <= bit_idx_r + 2'h1;
            state_r   <= serial_gpio_pkg::ST_LOW;
          end else if (phase_end) begin
            bit_idx_r  <= '0;
            out_port_r <= next_out[4:0];
            in_port_r  <= next_in[4:0];
            state_r    <= next_out[5] ? serial_gpio_pkg::ST_FETCH : serial_gpio_pkg::ST_LOAD;
          end
        end
        // load after burst latches next inputs
        serial_gpio_pkg::ST_LOAD: begin
          phase_r    <= phase_r + 9'h001;
          step_cnt_r <= '0;
          gap_ms_r   <= '0;
          if (load_end) begin
            state_r <= (gen_r.repeat_bursts && !gen_r.gap_disable) ?
                       serial_gpio_pkg::ST_GAP : serial_gpio_pkg::ST_IDLE;
          end
        end
        serial_gpio_pkg::ST_GAP: begin
          if (gap_end) begin
            state_r <= serial_gpio_pkg::ST_IDLE;
          end else if (step_cnt_r == 16'(GAP_STEP_CYCLES - 1)) begin
            step_cnt_r <= '0;
            gap_ms_r   <= gap_ms_r + 6'h01;
          end else begin
            step_cnt_r <= step_cnt_r + 16'h0001;
          end
        end
        default: state_r <= serial_gpio_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_chain_clock_out   <= 1'b0;
      o_chain_data_out    <= 1'b0;
      o_chain_load_strobe <= 1'b0;
      load_pol_r          <= 1'b0;
    end else begin
      load_pol_r          <= gen_r.load_polarity_sel;
      o_chain_clock_out   <= (state_r == serial_gpio_pkg::ST_HIGH && !phase_end) ||
                             (state_r == serial_gpio_pkg::ST_LOW && phase_end);
      o_chain_load_strobe <= (state_r == serial_gpio_pkg::ST_LOAD) ^
                             gen_r.load_polarity_sel;
      if (state_r == serial_gpio_pkg::ST_LOW && phase_r == 9'h000) begin
        o_chain_data_out <= bit_value;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      captured_inputs_r <= '0;
    end else if (sample_now) begin
      captured_inputs_r[cap_idx] <= din_sync_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || start_burst) begin
      burst_bits_r <= '0;
    end else if (sample_now) begin
      burst_bits_r <= burst_bits_r + 8'h01;
    end
  end

  logic load_act;
  assign load_act = o_chain_load_strobe ^ load_pol_r;

  a_bits_limit: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    burst_bits_r <= 8'(`SGC_MAX_BURST_BITS)) else $error("burst too long");
  a_bits_exact: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $rose(state_r == serial_gpio_pkg::ST_LOAD) |->
      burst_bits_r == 8'($countones(mask_lat_r) * (int'(gen_r.bits_per_port) + 1)))
    else $error("burst length differs from ports times width");
  a_skip_disabled: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    state_r == serial_gpio_pkg::ST_LOW |-> mask_lat_r[out_port_r] && mask_lat_r[in_port_r])
    else $error("disabled port shifted");
  a_load_pulse: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $rose(state_r == serial_gpio_pkg::ST_LOAD) |=> load_act ##1 !load_act)
    else $error("load strobe not a one-cycle pulse");
  a_go_clears: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    load_end && !wr_general |=> !gen_r.one_burst_go) else $error("single shot not cleared");
  a_repeat_gap: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    load_end && gen_r.repeat_bursts && !gen_r.gap_disable |=> state_r == serial_gpio_pkg::ST_GAP)
    else $error("no gap after repeated burst");
  a_gap_none: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    load_end && gen_r.repeat_bursts && gen_r.gap_disable && !wr_general |=>
      state_r == serial_gpio_pkg::ST_IDLE ##1 state_r != serial_gpio_pkg::ST_IDLE)
    else $error("gap inserted although disabled");
  a_clock_rise: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    sample_now |=> o_chain_clock_out) else $error("clock not high after sample");
  a_data_stable: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    state_r == serial_gpio_pkg::ST_HIGH |=> $stable(o_chain_data_out))
    else $error("data changed while clock high");
  a_capture: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    sample_now |=> captured_inputs_r[$past(cap_idx)] == $past(din_sync_r))
    else $error("input bit not captured");
  a_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    state_r == serial_gpio_pkg::ST_IDLE [*2] |-> !o_chain_clock_out && !load_act)
    else $error("chain pins active while idle");
  a_flip_start: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    start_burst && gen_r.flip_out_order && port_enable_mask_r != 32'h0000_0000 |=>
      (mask_lat_r >> out_port_r) == 32'h0000_0001)
    else $error("reversed output does not start at top port");

  c_single: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    gen_r.one_burst_go ##1 load_end);
  c_gap: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    state_r == serial_gpio_pkg::ST_GAP ##1 gap_end);
  c_flip_in: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    sample_now && gen_r.flip_in_order);
  c_width4: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    sample_now && bit_idx_r == 2'h3);
endmodule
`default_nettype wire

// >>> shared/serial_gpio_pkg.sv
// Types shared by the serial chain controller files
package serial_gpio_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_LOW   = 3'b010,
    ST_HIGH  = 3'b011,
    ST_LOAD  = 3'b100,
    ST_GAP   = 3'b101
  } shift_state_e;

  typedef enum logic [1:0] {
    SRC_LOW      = 2'h0,
    SRC_HIGH     = 2'h1,
    SRC_BLINK    = 2'h2,
    SRC_ACTIVITY = 2'h3
  } bit_source_e;

  typedef struct packed {
    logic       flip_out_order;
    logic       flip_in_order;
    logic [4:0] gap_length;
    logic       gap_disable;
    logic       load_polarity_sel;
    logic [1:0] bits_per_port;
    logic       repeat_bursts;
    logic       one_burst_go;
  } general_config_s;

  typedef struct packed {
    logic [3:0]      pwm_en;
    logic [3:0]      invert;
    bit_source_e [3:0] src;
  } port_cfg_s;

endpackage

// >>> shared/serial_gpio_shift_chain_defines.svh
// Offsets, field positions, reset values and timing counts of the serial chain controller
`ifndef SERIAL_GPIO_SHIFT_CHAIN_DEFINES_SVH
`define SERIAL_GPIO_SHIFT_CHAIN_DEFINES_SVH

`define SGC_ADDR_W          8
`define SGC_DATA_W          32
`define SGC_OFS_GENERAL     8'h00
`define SGC_OFS_CLOCK       8'h04
`define SGC_OFS_ENABLE      8'h08
`define SGC_OFS_PWM         8'h0c
`define SGC_OFS_CAPT0       8'h10
`define SGC_OFS_CAPT3       8'h1c
`define SGC_OFS_PORT_BIT    7
`define SGC_GENERAL_W       13
`define SGC_BUSY_BIT        31
`define SGC_PORT_CFG_W      16
`define SGC_RST_GENERAL     13'h0000
`define SGC_RST_CLOCK       8'h08
`define SGC_RST_ENABLE      32'h0000_0000
`define SGC_RST_PWM         8'h80
`define SGC_NUM_PORTS       32
`define SGC_BITS_PER_PORT   4
`define SGC_MAX_BURST_BITS  128
`define SGC_HALF_EXTRA      2
`define SGC_REF_CLK_KHZ     10000
`define SGC_REF_PERIOD_NS   100
`define SGC_GAP_STEP_US     1000
`define SGC_BLINK_HALF_US   25000
`define SGC_LOAD_MIN_NS     25
`define SGC_LOAD_MAX_NS     30

`endif

// >>> tb/chain_board_model.sv
// Board shift register chain with output latches and a loadable input stage
`timescale 1ns/100ps
`default_nettype none
module chain_board_model #(
  parameter int STAGES = 4
) (
  input  wire logic              i_clk,
  input  wire logic              i_data,
  input  wire logic              i_load,
  input  wire logic              i_load_low,
  input  wire logic [STAGES-1:0] i_par,
  output logic                   o_data,
  output logic      [STAGES-1:0] o_par
);
  logic [STAGES-1:0] out_sr;
  logic [STAGES-1:0] in_sr = '0;
  wire               load_act = i_load ^ i_load_low;

  always @(posedge i_clk or posedge load_act) begin
    if (load_act) begin
      o_par <= out_sr;
      in_sr <= i_par;
    end else begin
      out_sr <= {out_sr[STAGES-2:0], i_data};
      in_sr  <= {~in_sr[0], in_sr[STAGES-1:1]};
    end
  end

  assign o_data = in_sr[0];
endmodule
`default_nettype wire

// >>> tb/serial_gpio_shift_chain_test.sv
// Self-checking bench for the serial chain controller
`timescale 1ns/100ps
`default_nettype none
module serial_gpio_shift_chain_test;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
  } row_s;
  row_s        rows [13] = '{
    '{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h04, 1'b0, 32'h0, 32'h8},
    '{8'h08, 1'b0, 32'h0, 32'h0}, '{8'h0c, 1'b0, 32'h0, 32'h80},
    '{8'h10, 1'b0, 32'h0, 32'h0}, '{8'h14, 1'b0, 32'h0, 32'h0},
    '{8'h18, 1'b0, 32'h0, 32'h0}, '{8'h1c, 1'b0, 32'h0, 32'h0},
    '{8'h40, 1'b1, 32'h5a, 32'h0}, '{8'h04, 1'b1, 32'h2, 32'h2},
    '{8'h08, 1'b1, 32'h5, 32'h5}, '{8'h80, 1'b1, 32'h1, 32'h1},
    '{8'h88, 1'b1, 32'h200, 32'h200}};
  logic        ref_clk;
  logic        srst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        pol = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] act = 32'h5;
  logic [3:0]  par = 4'b1011;
  logic [31:0] rdata, d;
  logic [31:0] seq = 32'h0;
  logic [3:0]  board;
  logic        cko, dout, ld, din;
  logic        cko_q = 1'b0;
  logic        act_q = 1'b0;
  int          err_total = 0, num_checks = 0, t_a, t1, t2;
  int          hi_cnt = 0, hi_last = 0, ld_len = 0, ld_cnt = 0, ld_at = 0, cyc = 0, nbits = 0;

  serial_gpio_shift_chain #(
    .GAP_STEP_CYCLES  (20),
    .BLINK_HALF_CYCLES(8)
  ) serial_gpio_shift_chain_inst (
    .i_ref_clk          (ref_clk),
    .i_srst             (srst),
    .i_addr             (addr),
    .i_wdata            (wdata),
    .i_wr               (wr),
    .i_rd               (rd),
    .o_rdata            (rdata),
    .i_chain_data_in    (din),
    .i_port_activity    (act),
    .o_chain_clock_out  (cko),
    .o_chain_data_out   (dout),
    .o_chain_load_strobe(ld)
  );

  chain_board_model #(.STAGES(4)) chain_board_model_inst (
    .i_clk     (cko),
    .i_data    (dout),
    .i_load    (ld),
    .i_load_low(pol),
    .i_par     (par),
    .o_data    (din),
    .o_par     (board)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Serial bits, clock high length and load pulses
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    cko_q <= cko;
    act_q <= ld ^ pol;
    hi_cnt <= cko ? hi_cnt + 1 : 0;
    if (cko && !cko_q) begin
      seq <= {seq[30:0], dout};
      nbits <= nbits + 1;
    end
    if (!cko && cko_q) hi_last <= hi_cnt;
    if ((ld ^ pol) && !act_q) begin
      ld_cnt <= ld_cnt + 1;
      ld_at <= cyc;
      ld_len <= 1;
    end else if (ld ^ pol) ld_len <= ld_len + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    v = rdata;
  endtask

  task automatic wait_ld(input int n);
    int l0;
    l0 = ld_cnt;
    for (int i = 0; i < 3000 && ld_cnt < l0 + n; i++) @(posedge ref_clk);
  endtask

  task automatic burst(input logic [31:0] cfg);
    int l0, n0;
    l0 = ld_cnt;
    n0 = nbits;
    wr_reg(8'h00, cfg | 32'h1);
    wait_ld(1);
    repeat (4) @(posedge ref_clk);
    check(ld_cnt - l0, 1);
    check(ld_len, 1);
    check(nbits - n0, 4);
    rd_reg(8'h00, d);
    check(d, cfg);
  endtask

  task automatic complete_run;
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    complete_run;
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, d);
      check(d, rows[i].e);
    end
    burst(32'h4);
    check(seq[3:0], 4'b1001);
    check(board, 4'b1001);
    check(hi_last, 4);
    rd_reg(8'h10, d);
    check(d, 32'h0);
    burst(32'h4);
    rd_reg(8'h10, d);
    check(d, 32'h203);
    burst(32'h1804);
    check(seq[3:0], 4'b0110);
    check(board, 4'b0110);
    rd_reg(8'h10, d);
    check(d, 32'h302);
    pol <= 1'b1;
    wr_reg(8'h00, 32'h14);
    repeat (4) @(posedge ref_clk);
    burst(32'h14);
    check(board, 4'b1001);
    pol <= 1'b0;
    wr_reg(8'h00, 32'h4);
    repeat (4) @(posedge ref_clk);
    act <= 32'h0;
    wr_reg(8'h0c, 32'h0);
    wr_reg(8'h80, 32'h100d);
    burst(32'h4);
    check(seq[3:0], 4'b0001);
    wr_reg(8'h00, 32'h26);
    wait_ld(2);
    t_a = ld_at;
    wait_ld(1);
    t1 = ld_at - t_a;
    wr_reg(8'h00, 32'h46);
    wait_ld(2);
    t_a = ld_at;
    wait_ld(1);
    t2 = ld_at - t_a;
    check({31'h0, (t2 - t1 >= 40 && t2 - t1 <= 41)}, 32'h1);
    wr_reg(8'h00, 32'h4);
    repeat (300) @(posedge ref_clk);
    t_a = ld_cnt;
    repeat (300) @(posedge ref_clk);
    check(ld_cnt - t_a, 0);
    rd_reg(8'h00, d);
    check(d, 32'h4);
    wr_reg(8'h00, 32'h5);
    repeat (10) @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    check({cko, dout, ld}, 3'b000);
    rd_reg(8'h00, d);
    check(d, 32'h0);
    complete_run;
  end
endmodule
`default_nettype wire
